// *** torque_limit_select.v ***
/*
 Holds the torque limit selector of a servo drive with its AXI4-Lite
 register slave. Assumes digital inputs synchronous to clk, a torque
 command in percent (signed 16 bit) and an analog reference already
 converted to percent (signed 16 bit).
*/
`include "torque_limit_defs.vh"

// How it works
// - Internal forward/reverse limits 0..300 percent always apply.
// - Internal limits reset to 300 percent.
// - Any limit is capped at the motor's real maximum torque.
// - External limits 0..300 percent, reset to 100.
// - Forward select low: smaller of forward internal and external.
// - Reverse select low: smaller of reverse internal and external.
// - Single axis: forward select on input seven, reverse on eight.
// - Two-axis: input allocation register picks the terminals.
// - Analog limit only in speed or position control; the code also enables it with the undefined mode value 3.
// - Analog limit uses absolute value, applied to both directions.
// - Option value 1 routes analog reference to torque limit.
// - Option value 22 means feed-forward; never both at once.
// - Direction digit 0 treats counter-clockwise as forward.
// - Functions sharing one terminal are combined with OR.
// - Select inputs are sampled with at most 2 ms lag.
module torque_limit_select
(
   // Clock and reset
   input wire clk,
   input wire nrst,
   // General digital inputs, active low, index 0 is input one
   input wire [7:0] digitalInput_n,
   // Analog torque reference in percent, signed
   input wire [15:0] analogRef,
   // Torque command in percent, signed, and clamped result
   input wire [15:0] torqueCmd,
   output reg [15:0] torqueOut,
   output reg [8:0] fwdLimit,
   output reg [8:0] revLimit,
   output reg feedForwardEn,
   // AXI4-Lite write address and data
   input wire [7:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   output reg s_axi_awready,
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output reg s_axi_wready,
   // AXI4-Lite write response
   output reg [1:0] s_axi_bresp,
   output reg s_axi_bvalid,
   input wire s_axi_bready,
   // AXI4-Lite read
   input wire [7:0] s_axi_araddr,
   input wire s_axi_arvalid,
   output reg s_axi_arready,
   output reg [31:0] s_axi_rdata,
   output reg [1:0] s_axi_rresp,
   output reg s_axi_rvalid,
   input wire s_axi_rready
);

////////////////////////////////////////////////////////////////////////
// Registers
reg [8:0] fwdInt;
reg [8:0] revInt;
reg [8:0] fwdExt;
reg [8:0] revExt;
reg [8:0] motorMax;
reg [1:0] ctrlMode;
reg [7:0] speedOption;
reg [31:0] route;
reg [7:0] awAddr;
reg awHeld;
reg [31:0] wData;
reg [3:0] wStrb;
reg wHeld;
reg [16:0] sampleCnt;
reg fwdSel;
reg revSel;

////////////////////////////////////////////////////////////////////////
// Write handling: merge byte lanes, clip to the legal range
function [8:0] merge_pct;
   input [8:0] old;
   input [31:0] data;
   input [3:0] strb;
   reg [15:0] v;
   begin
      v = {strb[1] ? data[15:8] : {7'h00, old[8]}, strb[0] ? data[7:0] : old[7:0]};
      merge_pct = (v > {7'h00, `LIM_MAX}) ? `LIM_MAX : v[8:0];
   end
endfunction

function [31:0] merge_word;
   input [31:0] old;
   input [31:0] data;
   input [3:0] strb;
   integer i;
   begin
      merge_word = old;
      for (i = 0; i < 4; i = i + 1)
         if (strb[i])
            merge_word[i*8 +: 8] = data[i*8 +: 8];
   end
endfunction

wire awGot = awHeld || (s_axi_awvalid && s_axi_awready);
wire wGot = wHeld || (s_axi_wvalid && s_axi_wready);
wire [7:0] wrAddr = awHeld ? awAddr : s_axi_awaddr;
wire [31:0] wrData = wHeld ? wData : s_axi_wdata;
wire [3:0] wrStrb = wHeld ? wStrb : s_axi_wstrb;
wire doWrite = awGot && wGot && !s_axi_bvalid;
wire wrMapped = (wrAddr <= `OFS_CMD) && (wrAddr[1:0] == 2'h0) && (wrAddr != `OFS_CMD);

// Address and data may arrive in either order; response after both
always @(posedge clk)
begin
   if (!nrst)
   begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      awHeld <= 1'b0;
      wHeld <= 1'b0;
      awAddr <= 8'h00;
      wData <= 32'h0000_0000;
      wStrb <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
      fwdInt <= `INT_RESET;
      revInt <= `INT_RESET;
      fwdExt <= `EXT_RESET;
      revExt <= `EXT_RESET;
      motorMax <= `MOTOR_MAX_RESET;
      ctrlMode <= `MODE_SPEED;
      speedOption <= 8'h00;
      route <= `ROUTE_RESET;
   end
   else
   begin
      if (s_axi_awvalid && s_axi_awready)
      begin
         awAddr <= s_axi_awaddr;
         awHeld <= 1'b1;
         s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
         wData <= s_axi_wdata;
         wStrb <= s_axi_wstrb;
         wHeld <= 1'b1;
         s_axi_wready <= 1'b0;
      end
      if (doWrite)
      begin
         awHeld <= 1'b0;
         wHeld <= 1'b0;
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b1;
         s_axi_bresp <= wrMapped ? 2'h0 : 2'h2;
         case (wrAddr)
            `OFS_FWD_INT: fwdInt <= merge_pct(fwdInt, wrData, wrStrb);
            `OFS_REV_INT: revInt <= merge_pct(revInt, wrData, wrStrb);
            `OFS_FWD_EXT: fwdExt <= merge_pct(fwdExt, wrData, wrStrb);
            `OFS_REV_EXT: revExt <= merge_pct(revExt, wrData, wrStrb);
            `OFS_MOTOR_MAX: motorMax <= merge_pct(motorMax, wrData, wrStrb);
            `OFS_MODE:
            begin
               if (wrStrb[0])
                  ctrlMode <= wrData[1:0];
               if (wrStrb[1])
                  speedOption <= wrData[15:8];
            end
            `OFS_ROUTE: route <= merge_word(route, wrData, wrStrb);
            default: ;
         endcase
      end
      else if (s_axi_bvalid && s_axi_bready)
      begin
         s_axi_bvalid <= 1'b0;
         s_axi_awready <= 1'b1;
         s_axi_wready <= 1'b1;
      end
   end
end

////////////////////////////////////////////////////////////////////////
// Select input sampling every 2 ms; the lag is allowed and it filters
// contact bounce the host may leave on the terminals
wire [2:0] fwdPin = route[`RT_FWD_LSB +: 3];
wire [2:0] revPin = route[`RT_REV_LSB +: 3];
// Fixed allocation on a single-axis unit, register choice on two-axis
wire [2:0] fwdIdx = route[`RT_TWO_AXIS] ? fwdPin : 3'h6;
wire [2:0] revIdx = route[`RT_TWO_AXIS] ? revPin : 3'h7;
// A terminal shared with other functions acts as the OR of them all
wire fwdActive = ~digitalInput_n[fwdIdx];
wire revActive = ~digitalInput_n[revIdx];

always @(posedge clk)
begin
   if (!nrst)
   begin
      sampleCnt <= 17'h00000;
      fwdSel <= 1'b0;
      revSel <= 1'b0;
   end
   else if (sampleCnt == `SAMPLE_CYCLES - 1)
   begin
      sampleCnt <= 17'h00000;
      fwdSel <= fwdActive;
      revSel <= revActive;
   end
   else
      sampleCnt <= sampleCnt + 17'h00001;
end

////////////////////////////////////////////////////////////////////////
// Limit selection
// Analog limit only outside torque mode and only with option 1
wire analogOn = (ctrlMode != `MODE_TORQUE) && (speedOption == `OPT_ANALOG_LIM);
// Feed-forward only with option 22, which excludes the analog limit
wire next_feedForwardEn = (speedOption == `OPT_FEEDFWD);
// Sign of the reference is ignored
wire [15:0] analogAbs = analogRef[15] ? (~analogRef + 16'h0001) : analogRef;
wire [8:0] analogPct = (analogAbs > {7'h00, `LIM_MAX}) ? `LIM_MAX : analogAbs[8:0];
// Direction digit 1 swaps which pin selects which side
wire dirSwap = route[`RT_DIR];
wire useFwdExt = dirSwap ? revSel : fwdSel;
wire useRevExt = dirSwap ? fwdSel : revSel;
wire [8:0] fwdBase;
wire [8:0] revBase;
wire [8:0] fwdPick;
wire [8:0] revPick;

limit_clamp fwdClamp
(
   .intLimit(fwdInt),
   .extLimit(fwdExt),
   .motorMax(motorMax),
   .useExt(useFwdExt),
   .limit(fwdBase)
);

limit_clamp revClamp
(
   .intLimit(revInt),
   .extLimit(revExt),
   .motorMax(motorMax),
   .useExt(useRevExt),
   .limit(revBase)
);

// Same analog limit applied to both directions
assign fwdPick = (analogOn && analogPct < fwdBase) ? analogPct : fwdBase;
assign revPick = (analogOn && analogPct < revBase) ? analogPct : revBase;

////////////////////////////////////////////////////////////////////////
// Command saturation, updated every cycle
wire [15:0] fwdCap = {7'h00, fwdPick};
wire [15:0] revCap = ~{7'h00, revPick} + 16'h0001;
wire cmdNeg = torqueCmd[15];
wire overFwd = !cmdNeg && (torqueCmd > fwdCap);
wire underRev = cmdNeg && ($signed(torqueCmd) < $signed(revCap));

always @(posedge clk)
begin
   if (!nrst)
   begin
      torqueOut <= 16'h0000;
      fwdLimit <= `INT_RESET;
      revLimit <= `INT_RESET;
      feedForwardEn <= 1'b0;
   end
   else
   begin
      fwdLimit <= fwdPick;
      revLimit <= revPick;
      feedForwardEn <= next_feedForwardEn;
      if (overFwd)
         torqueOut <= fwdCap;
      else if (underRev)
         torqueOut <= revCap;
      else
         torqueOut <= torqueCmd;
   end
end

////////////////////////////////////////////////////////////////////////
// Read channel: one cycle to answer, SLVERR on unmapped offsets
reg [31:0] next_rdata;
reg next_rok;
always @*
begin
   next_rok = 1'b1;
   case (s_axi_araddr)
      `OFS_FWD_INT: next_rdata = {23'h000000, fwdInt};
      `OFS_REV_INT: next_rdata = {23'h000000, revInt};
      `OFS_FWD_EXT: next_rdata = {23'h000000, fwdExt};
      `OFS_REV_EXT: next_rdata = {23'h000000, revExt};
      `OFS_MOTOR_MAX: next_rdata = {23'h000000, motorMax};
      `OFS_MODE: next_rdata = {16'h0000, speedOption, 6'h00, ctrlMode};
      `OFS_ROUTE: next_rdata = route;
      `OFS_ANALOG: next_rdata = {23'h000000, analogPct};
      `OFS_STATUS: next_rdata = {20'h00000, 1'b0, feedForwardEn, analogOn, 1'b0,
         revSel, fwdSel, revLimit[8], fwdLimit[8], 4'h0};
      `OFS_OUT_CMD: next_rdata = {7'h00, revLimit, torqueOut};
      default:
      begin
         next_rdata = 32'h0000_0000;
         next_rok = 1'b0;
      end
   endcase
end

always @(posedge clk)
begin
   if (!nrst)
   begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= 2'h0;
   end
   else if (s_axi_arvalid && s_axi_arready)
   begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= next_rdata;
      s_axi_rresp <= next_rok ? 2'h0 : 2'h2;
   end
   else if (s_axi_rvalid && s_axi_rready)
   begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
   end
end

endmodule // torque_limit_select

// *** torque_limit_defs.vh ***
/*
 Holds the register offsets, field positions, reset values and timing
 counts of the torque limit selector. Assumes inclusion by bare name.
*/
`ifndef TORQUE_LIMIT_DEFS_VH
`define TORQUE_LIMIT_DEFS_VH

// Register byte offsets
`define OFS_FWD_INT 8'h00
`define OFS_REV_INT 8'h04
`define OFS_FWD_EXT 8'h08
`define OFS_REV_EXT 8'h0c
`define OFS_MOTOR_MAX 8'h10
`define OFS_MODE 8'h14
`define OFS_ROUTE 8'h18
`define OFS_CMD 8'h1c
`define OFS_ANALOG 8'h20
`define OFS_STATUS 8'h24
`define OFS_OUT_CMD 8'h28

// Limit range and reset values in percent of rated torque
`define LIM_MAX 9'h12c
`define INT_RESET 9'h12c
`define EXT_RESET 9'h064
`define MOTOR_MAX_RESET 9'h12c

// Control mode field values
`define MODE_SPEED 2'h0
`define MODE_POS 2'h1
`define MODE_TORQUE 2'h2

// Speed-control option digit values
`define OPT_ANALOG_LIM 8'h01
`define OPT_FEEDFWD 8'h22

// Route register fields: forward input select [2:0], reverse [6:4],
// two-axis flag bit 8, direction digit bit 12
`define RT_FWD_LSB 0
`define RT_REV_LSB 4
`define RT_TWO_AXIS 8
`define RT_DIR 12
`define ROUTE_RESET 32'h0000_0076

// Sampling period of the select inputs: 2 ms at 50 MHz
`define SAMPLE_MS 2
`define CLK_KHZ 50000
`define SAMPLE_CYCLES (`SAMPLE_MS * `CLK_KHZ)

`endif

// *** limit_clamp.v ***
/*
 Holds one clamp stage: picks the lower of two limits and the motor
 maximum. Assumes all inputs are unsigned percentages.
*/
module limit_clamp
(
   // Limits in percent
   input wire [8:0] intLimit,
   input wire [8:0] extLimit,
   input wire [8:0] motorMax,
   // Select the external limit as well
   input wire useExt,
   // Resulting limit
   output wire [8:0] limit
);

////////////////////////////////////////////////////////////////////////
// Smaller of internal and, when selected, external
wire [8:0] pick;
assign pick = (useExt && extLimit < intLimit) ? extLimit : intLimit;
// Never beyond the motor's real maximum
assign limit = (pick > motorMax) ? motorMax : pick;

endmodule // limit_clamp

// *** limit_host.sv ***
/*
 Host controller model that drives the limit-select inputs.
 Assumes the factory single-axis terminal map of the drive.
*/
module limit_host
(
   // Requested select states, high = ON
   input logic fwdOn,
   input logic revOn,
   // General inputs toward the drive, active low
   output logic [7:0] digitalInput_n
);
   // Other functions stay idle so no shared terminal ORs into a select
   assign digitalInput_n = {~revOn, ~fwdOn, 6'h3f};
endmodule // limit_host

// *** torque_limit_select_monitor.sv ***
/*
 Checker of the torque limit selector's ports.
 Assumes a bind onto torque_limit_select.
*/
module torque_limit_select_monitor
(
   // Clock and reset
   input logic clk,
   input logic nrst,
   // Limit path
   input logic [15:0] torqueCmd,
   input logic [15:0] torqueOut,
   input logic [8:0] fwdLimit,
   input logic [8:0] revLimit,
   // Bus handshakes
   input logic s_axi_awvalid,
   input logic s_axi_awready,
   input logic s_axi_wvalid,
   input logic s_axi_wready,
   input logic s_axi_bvalid,
   input logic s_axi_bready,
   input logic [1:0] s_axi_bresp,
   input logic s_axi_arvalid,
   input logic s_axi_arready,
   input logic s_axi_rvalid,
   input logic s_axi_rready,
   input logic [31:0] s_axi_rdata
);
   default clocking @(posedge clk); endclocking
   default disable iff (!nrst);
   ////////////////////////////////////////////////////////////////////
   // Limit path; a stable limit keeps either pipeline reading exact
   a_pos_clamp: assert property ($signed(torqueCmd) > 0 ##1 $stable(fwdLimit) |->
      torqueOut == (($signed($past(torqueCmd)) > $signed({7'h00, fwdLimit})) ?
      {7'h00, fwdLimit} : $past(torqueCmd))) else $error("positive clamp wrong");
   a_neg_clamp: assert property ($signed(torqueCmd) < 0 ##1 $stable(revLimit) |->
      torqueOut == (($signed($past(torqueCmd)) < $signed(16'h0 - {7'h00, revLimit})) ?
      16'h0 - {7'h00, revLimit} : $past(torqueCmd))) else $error("negative clamp wrong");
   a_limit_range: assert property (fwdLimit <= 9'h12c && revLimit <= 9'h12c)
      else $error("limit above range");
   a_reset_limits: assert property ($rose(nrst) |-> fwdLimit == 9'h12c &&
      revLimit == 9'h12c && torqueOut == 16'h0000) else $error("reset values wrong");
   ////////////////////////////////////////////////////////////////////
   // Register bus answers
   a_write_ans: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
      s_axi_wready |=> s_axi_bvalid && !s_axi_awready) else $error("no write answer");
   a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
      s_axi_bvalid && $stable(s_axi_bresp)) else $error("write answer dropped");
   a_read_ans: assert property (s_axi_arvalid && s_axi_arready |=>
      s_axi_rvalid && !s_axi_arready) else $error("no read answer");
   a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
      s_axi_rvalid && $stable(s_axi_rdata)) else $error("read answer dropped");
   // Main scenarios
   c_refused: cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
   c_low_fwd: cover property (fwdLimit < 9'h064);
   c_neg_cmd: cover property ($signed(torqueCmd) < 0 && revLimit != 9'h12c);
endmodule // torque_limit_select_monitor

bind torque_limit_select torque_limit_select_monitor i_torque_limit_select_monitor (.clk,
   .nrst, .torqueCmd, .torqueOut, .fwdLimit, .revLimit, .s_axi_awvalid, .s_axi_awready,
   .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid,
   .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata);

// *** torque_limit_select_tb.sv ***
/*
 Self-checking bench of the torque limit selector.
 Assumes the host model drives the select inputs.
*/
`include "torque_limit_defs.vh"
module torque_limit_select_tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk = 1'b0, nrst = 1'b0, fwdOn = 1'b0, revOn = 1'b0;
   logic [7:0] digitalInput_n, awaddr = 8'h00, araddr = 8'h00;
   logic [15:0] analogRef = 16'h0000, torqueCmd = 16'h0000, torqueOut;
   logic [8:0] fwdLimit, revLimit;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic awready, wready, bvalid, arready, rvalid, feedForwardEn;
   logic [31:0] wdata = 32'h0, rdata, rd;
   logic [1:0] bresp, rresp, rsp;
   int numErrors = 0, compares = 0, cyc = 0;
   limit_host i_limit_host (.fwdOn(fwdOn), .revOn(revOn), .digitalInput_n(digitalInput_n));
   torque_limit_select i_torque_limit_select (.clk(clk), .nrst(nrst),
      .digitalInput_n(digitalInput_n), .analogRef(analogRef), .torqueCmd(torqueCmd),
      .torqueOut(torqueOut), .fwdLimit(fwdLimit), .revLimit(revLimit),
      .feedForwardEn(feedForwardEn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
   ////////////////////////////////////////////////////////////////////
   // 50 MHz clock and a cycle ceiling against hangs
   initial
   begin
      forever #10 clk = ~clk;
   end
   always @(posedge clk)
   begin
      cyc <= cyc + 1;
      if (cyc == 110000)
      begin
         numErrors++;
         wrapUp;
      end
   end
   task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
      compares++;
      if (g !== e)
      begin
         numErrors++;
         $display("MISMATCH %s expected %h seen %h", s, e, g);
      end
   endtask
   // Bus cycles; ready is raised late so the hold checks see a wait
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      forever
      begin
         @(posedge clk);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
         if (bvalid && bready) break;
         if (bvalid) bready <= 1'b1;
      end
      rsp = bresp;
      bready <= 1'b0;
   endtask
   task automatic rdr(input logic [7:0] a);
      @(posedge clk);
      araddr <= a;
      arvalid <= 1'b1;
      forever
      begin
         @(posedge clk);
         if (arvalid && arready) arvalid <= 1'b0;
         if (rvalid && rready) break;
         if (rvalid) rready <= 1'b1;
      end
      rd = rdata;
      rsp = rresp;
      rready <= 1'b0;
   endtask
   task automatic settle(input int n);
      repeat (n) @(posedge clk);
   endtask
   ////////////////////////////////////////////////////////////////////
   // Scenarios
   task automatic tResetValues;
      rdr(`OFS_FWD_INT); chk("fwd int", 32'h12c, rd);
      rdr(`OFS_REV_EXT); chk("rev ext", 32'h064, rd);
      chk("fwd off", 9'h12c, fwdLimit);
      chk("rev off", 9'h12c, revLimit);
   endtask
   task automatic tClampCommand;
      wr(`OFS_FWD_INT, 32'h190); rdr(`OFS_FWD_INT); chk("clip", 32'h12c, rd);
      wr(`OFS_FWD_INT, 32'h0fa);
      wr(`OFS_REV_INT, 32'h0c8);
      torqueCmd <= 16'h0190; settle(3); chk("pos", 16'h00fa, torqueOut);
      torqueCmd <= 16'hfe70; settle(3); chk("neg", 16'hff38, torqueOut);
      wr(`OFS_MOTOR_MAX, 32'h096); settle(2); chk("motor cap", 9'h096, fwdLimit);
      wr(`OFS_MOTOR_MAX, 32'h12c);
   endtask
   // Only the forward select is ON, so a direction swap shows up on both sides
   task automatic tSelectAndAnalog;
      wr(`OFS_FWD_EXT, 32'h050);
      wr(`OFS_REV_EXT, 32'h078);
      fwdOn <= 1'b1;
      revOn <= 1'b0;
      settle(`SAMPLE_CYCLES + 5);
      chk("fwd on", 9'h050, fwdLimit);
      chk("rev off", 9'h0c8, revLimit);
      rdr(`OFS_STATUS); chk("status", 32'h040, rd);
      wr(`OFS_ROUTE, 32'h1076); settle(2);
      chk("swap fwd", 9'h0fa, fwdLimit);
      chk("rev on", 9'h078, revLimit);
      wr(`OFS_ROUTE, 32'h0076); settle(2);
      chk("fwd back", 9'h050, fwdLimit);
      wr(`OFS_MODE, 32'h0100); analogRef <= 16'hffce; settle(3);
      chk("abs fwd", 9'h032, fwdLimit);
      chk("abs rev", 9'h032, revLimit);
      rdr(`OFS_ANALOG); chk("abs value", 32'h032, rd);
      wr(`OFS_MODE, 32'h0101); settle(3); chk("pos mode", 9'h032, fwdLimit);
      wr(`OFS_MODE, 32'h0102); settle(3); chk("torque mode", 9'h050, fwdLimit);
      wr(`OFS_MODE, 32'h2200); settle(3); chk("ff", 1'b1, feedForwardEn);
      chk("ff no limit", 9'h050, fwdLimit);
   endtask
   task automatic tUnmapped;
      wr(8'h3c, 32'h1); chk("bad write", 2'h2, rsp);
      rdr(8'h3c); chk("bad read", 2'h2, rsp);
   endtask
   task automatic wrapUp;
      $display("comparisons %0d mismatches %0d", compares, numErrors);
      if (numErrors == 0 && compares > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   // Main sequence
   initial
   begin
      settle(10);
      nrst <= 1'b1;
      tResetValues;
      tClampCommand;
      tSelectAndAnalog;
      tUnmapped;
      wrapUp;
   end
endmodule // torque_limit_select_tb
